// ---- hdl/pisr_core_if.sv ----
`timescale 1ns/1ps
interface pisr_core_if;
    import pisr_pkg::*;
    logic [NCORES*4-1:0] core_req;
    logic [NCORES*NTHREADS-1:0] thread_active;
    logic [3:0] core_min;
    modport resolver (input core_req, input thread_active, output core_min);
    modport user (output core_req, output thread_active, input core_min);
endinterface

// ---- hdl/pisr_core_min.sv ----
`timescale 1ns/1ps
module pisr_core_min
    import pisr_pkg::*;
(
    pisr_core_if.resolver cif
);

    // resolve one core: any active thread forces the active state
    function automatic logic [3:0] pisr_core_state(
        input logic [3:0] req,
        input logic [NTHREADS-1:0] act
    );
        logic [3:0] s;
        s = req;
        if (|act) begin
            s = 4'h0;
        end
        return s;
    endfunction

    always_comb begin
        logic [3:0] m;
        logic [3:0] c;
        m = 4'hf;
        c = 4'h0;
        for (int i = 0; i < NCORES; i++) begin
            c = pisr_core_state(cif.core_req[i*4 +: 4],
                cif.thread_active[i*NTHREADS +: NTHREADS]);
            if (c < m) begin
                m = c;
            end
        end
        cif.core_min = m;
    end

endmodule

// ---- hdl/pisr_pkg.sv ----
package pisr_pkg;

    // package and core idle state codes, numerically ordered by depth
    typedef enum logic [3:0] {
        PK_C0 = 4'h0,
        PK_C2 = 4'h2,
        PK_C3 = 4'h3,
        PK_C6 = 4'h6,
        PK_C7 = 4'h7,
        PK_C7_SINGLE = 4'h8,
        PK_C8 = 4'h9,
        PK_C9 = 4'ha,
        PK_C10 = 4'hb
    } pisr_state_t;

    localparam int NCORES = 4;
    localparam int NTHREADS = 2;
    localparam int CACHE_WAYS = 8;

    // core request code for shallow core states
    localparam logic [3:0] CORE_C1 = 4'h1;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int FLUSH_WAY_NS = 100;
    localparam int FLUSH_WAY_CYC =
        (FLUSH_WAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // register offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;

    // control field positions and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_HEUR_BIT = 1;
    localparam int CTRL_TCOLD_BIT = 2;
    localparam int CTRL_LIM_LSB = 4;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic CTRL_HEUR_RST = 1'b0;
    localparam logic CTRL_TCOLD_RST = 1'b1;
    localparam logic [3:0] CTRL_LIM_RST = 4'hb;

    // status field positions
    localparam int ST_PKG_LSB = 0;
    localparam int ST_CMIN_LSB = 4;
    localparam int ST_PREV_LSB = 8;
    localparam int ST_WAY_LSB = 12;
    localparam int ST_SVCMEM_BIT = 16;
    localparam int ST_WAKE_BIT = 17;
    localparam int ST_SVCCORE_BIT = 18;
    localparam int ST_LLCOFF_BIT = 19;

    // synchronised platform pin positions
    localparam int SY_LAT_LSB = 0;
    localparam int SY_TIMER = 4;
    localparam int SY_GFX = 5;
    localparam int SY_DOFF = 6;
    localparam int SY_SELF_REF = 7;
    localparam int SY_SINGLE = 8;
    localparam int SY_SR_CAP = 9;
    localparam int SY_TCATT = 10;
    localparam int SY_MEMBRK = 11;
    localparam int SY_MEMPEND = 12;
    localparam int SY_HOLD = 13;
    localparam int NSYNC = 14;

endpackage

// ---- hdl/pisr_top.sv ----
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pisr_top
    import pisr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCORES*4-1:0] core_req,
    input wire logic [NCORES*NTHREADS-1:0] thread_active,
    input wire logic [NCORES-1:0] core_break,
    input wire logic break_masked,
    input wire logic [3:0] latency_tolerance_report,
    input wire logic timer_event_near,
    input wire logic graphics_deep_idle,
    input wire logic display_off,
    input wire logic panel_self_refresh,
    input wire logic single_embedded_panel,
    input wire logic panel_self_refresh_capable,
    input wire logic typec_attached,
    input wire logic mem_break,
    input wire logic mem_pending,
    input wire logic platform_hold,
    output logic [3:0] pkg_state,
    output logic [NCORES-1:0] core_wake,
    output logic mem_self_refresh,
    output logic base_clk_stop,
    output logic core_regulators_reduce,
    output logic last_level_cache_flushing,
    output logic last_level_cache_power_off,
    output logic io_supply,
    output logic regulator_low_power_state,
    output logic crystal_clk_stop,
    output logic typec_cold_state
);

    typedef struct packed {
        logic [NSYNC-1:0] sy1;
        logic [NSYNC-1:0] sy2;
        pisr_state_t pkg;
        pisr_state_t prev;
        logic svc_mem;
        logic svc_core;
        logic wake_hold;
        logic [3:0] way;
        logic [7:0] div;
        logic en;
        logic heur;
        logic tcold_en;
        logic [3:0] lim;
        logic [31:0] rdata;
        logic slverr;
        logic [NCORES-1:0] wake;
        logic msr;
        logic bclk;
        logic creg;
        logic flushing;
        logic llc_off;
        logic io_on;
        logic vr_lp;
        logic xtal;
        logic tcold;
    } pisr_regs_t;

    localparam logic [3:0] WAYS_ALL = 4'(CACHE_WAYS);
    localparam logic [7:0] DIV_LAST = 8'(FLUSH_WAY_CYC - 1);

    pisr_regs_t r;
    pisr_regs_t next_r;
    pisr_core_if cif();
    logic [NSYNC-1:0] pins;
    logic [3:0] core_min;
    pisr_state_t target;
    pisr_state_t step;

    function automatic logic [3:0] pisr_min(
        input logic [3:0] a,
        input logic [3:0] b
    );
        return (a < b) ? a : b;
    endfunction

    // one move toward the target, passing C2 next to C0
    function automatic pisr_state_t pisr_step(
        input pisr_state_t cur,
        input pisr_state_t tgt
    );
        pisr_state_t s;
        s = tgt;
        if (tgt == PK_C0 && cur > PK_C2) begin
            s = PK_C2;
        end else if (cur == PK_C0 && tgt > PK_C2) begin
            s = PK_C2;
        end
        return s;
    endfunction

    assign cif.core_req = core_req;
    assign cif.thread_active = thread_active;
    assign core_min = cif.core_min;

    pisr_core_min u_core_min (
        .cif(cif.resolver)
    );

    assign pins = {platform_hold, mem_pending, mem_break, typec_attached,
        panel_self_refresh_capable, single_embedded_panel, panel_self_refresh,
        display_off, graphics_deep_idle, timer_event_near,
        latency_tolerance_report};

    // deepest package state the present conditions allow
    always_comb begin
        logic [3:0] d;
        logic disp_ok;
        logic deep_req;
        disp_ok = r.sy2[SY_DOFF] | (r.sy2[SY_SELF_REF] & r.sy2[SY_SINGLE]
            & r.sy2[SY_SR_CAP]);
        deep_req = (core_min >= PK_C6) & r.sy2[SY_GFX];
        d = core_min;
        if (!disp_ok) begin
            d = pisr_min(d, PK_C8);
        end
        if (r.heur) begin
            d = pisr_min(d, r.lim);
        end
        d = pisr_min(d, r.sy2[SY_LAT_LSB +: 4]);
        if (r.sy2[SY_TIMER]) begin
            d = PK_C2;
        end
        if (d < PK_C3) begin
            d = PK_C2;
        end
        case (d)
            4'h2: target = PK_C2;
            4'h3: target = PK_C3;
            4'h4: target = PK_C3;
            4'h5: target = PK_C3;
            4'h6: target = PK_C6;
            4'h7: target = PK_C7;
            4'h8: target = PK_C7_SINGLE;
            4'h9: target = PK_C8;
            4'ha: target = PK_C9;
            4'hb: target = PK_C10;
            default: target = PK_C10;
        endcase
        if (!deep_req || !r.en || r.wake_hold) begin
            target = PK_C0;
        end else if (r.svc_mem || r.svc_core) begin
            target = PK_C2;
        end
        step = pisr_step(r.pkg, target);
    end

    always_comb begin
        logic acc;
        logic setup;
        logic [31:0] rd;
        logic brk;
        next_r = r;
        next_r.sy1 = pins;
        next_r.sy2 = r.sy1;
        acc = psel & penable;
        setup = psel & ~penable;
        rd = 32'h0;
        brk = 1'b0;

        // register writes land in the access phase
        if (acc && pwrite && paddr == CTRL_OFF) begin
            next_r.en = pwdata[CTRL_EN_BIT];
            next_r.heur = pwdata[CTRL_HEUR_BIT];
            next_r.tcold_en = pwdata[CTRL_TCOLD_BIT];
            next_r.lim = pwdata[CTRL_LIM_LSB +: 4];
        end

        // read data and error captured in setup, shown in access
        if (setup) begin
            next_r.slverr = 1'b0;
            case (paddr)
                CTRL_OFF: begin
                    rd[CTRL_EN_BIT] = r.en;
                    rd[CTRL_HEUR_BIT] = r.heur;
                    rd[CTRL_TCOLD_BIT] = r.tcold_en;
                    rd[CTRL_LIM_LSB +: 4] = r.lim;
                end
                STAT_OFF: begin
                    rd[ST_PKG_LSB +: 4] = r.pkg;
                    rd[ST_CMIN_LSB +: 4] = core_min;
                    rd[ST_PREV_LSB +: 4] = r.prev;
                    rd[ST_WAY_LSB +: 4] = r.way;
                    rd[ST_SVCMEM_BIT] = r.svc_mem;
                    rd[ST_WAKE_BIT] = r.wake_hold;
                    rd[ST_SVCCORE_BIT] = r.svc_core;
                    rd[ST_LLCOFF_BIT] = r.llc_off;
                end
                default: begin
                    next_r.slverr = pwrite ? 1'b1 : 1'b1;
                end
            endcase
            next_r.rdata = rd;
        end

        // release before a new break, so a fresh break wins
        if (r.wake_hold && core_min < PK_C6) begin
            next_r.wake_hold = 1'b0;
        end

        // core break while idle: wake and deliver to the target core
        brk = (|core_break) && r.pkg != PK_C0;
        next_r.wake = brk ? core_break : '0;
        if (brk && !break_masked) begin
            next_r.wake_hold = 1'b1;
            next_r.svc_core = 1'b0;
        end else if (brk) begin
            next_r.svc_core = 1'b1;
            next_r.prev = r.pkg;
        end else if (r.svc_core && r.pkg == PK_C2) begin
            next_r.svc_core = 1'b0;
        end

        // memory or snoop break from a deep state
        if (r.sy2[SY_MEMBRK] && r.pkg >= PK_C3) begin
            next_r.svc_mem = 1'b1;
            next_r.prev = r.pkg;
        end else if (r.svc_mem && !r.sy2[SY_MEMPEND]
            && !r.sy2[SY_HOLD]) begin
            next_r.svc_mem = 1'b0;
        end else if (r.svc_mem && r.sy2[SY_HOLD]) begin
            next_r.svc_mem = 1'b1;
        end

        next_r.pkg = step;

        // cache flush: progressive in C7, at once from single-flush C7 down
        next_r.div = 8'h0;
        if (r.pkg >= PK_C7_SINGLE) begin
            next_r.way = WAYS_ALL;
        end else if (r.pkg == PK_C7 && r.way != WAYS_ALL) begin
            next_r.div = r.div + 8'h1;
            if (r.div == DIV_LAST) begin
                next_r.div = 8'h0;
                next_r.way = r.way + 4'h1;
            end
        end else if (r.pkg < PK_C7) begin
            next_r.way = 4'h0;
        end

        next_r.msr = step >= PK_C3;
        next_r.bclk = step >= PK_C6;
        next_r.creg = step >= PK_C6;
        next_r.flushing = step == PK_C7
            && next_r.way != WAYS_ALL;
        next_r.llc_off = next_r.way == WAYS_ALL
            && step >= PK_C7;
        next_r.io_on = step != PK_C10;
        next_r.vr_lp = step == PK_C10;
        next_r.xtal = step == PK_C10;
        next_r.tcold = step == PK_C10 && r.tcold_en
            && !r.sy2[SY_TCATT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{
                sy1: '0,
                sy2: '0,
                pkg: PK_C0,
                prev: PK_C0,
                svc_mem: 1'b0,
                svc_core: 1'b0,
                wake_hold: 1'b0,
                way: 4'h0,
                div: 8'h0,
                en: CTRL_EN_RST,
                heur: CTRL_HEUR_RST,
                tcold_en: CTRL_TCOLD_RST,
                lim: CTRL_LIM_RST,
                rdata: 32'h0,
                slverr: 1'b0,
                wake: '0,
                msr: 1'b0,
                bclk: 1'b0,
                creg: 1'b0,
                flushing: 1'b0,
                llc_off: 1'b0,
                io_on: 1'b1,
                vr_lp: 1'b0,
                xtal: 1'b0,
                tcold: 1'b0
            };
        end else begin
            r <= next_r;
        end
    end

    assign pready = 1'b1;
    assign prdata = r.rdata;
    assign pslverr = r.slverr & psel & penable;
    assign pkg_state = r.pkg;
    assign core_wake = r.wake;
    assign mem_self_refresh = r.msr;
    assign base_clk_stop = r.bclk;
    assign core_regulators_reduce = r.creg;
    assign last_level_cache_flushing = r.flushing;
    assign last_level_cache_power_off = r.llc_off;
    assign io_supply = r.io_on;
    assign regulator_low_power_state = r.vr_lp;
    assign crystal_clk_stop = r.xtal;
    assign typec_cold_state = r.tcold;

endmodule

// ---- verif/pisr_monitor.sv ----
`timescale 1ns/1ps
module pisr_monitor
    import pisr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NCORES*NTHREADS-1:0] thread_active,
    input wire logic [NCORES-1:0] core_break,
    input wire logic [3:0] pkg_state,
    input wire logic [NCORES-1:0] core_wake,
    input wire logic mem_self_refresh,
    input wire logic base_clk_stop,
    input wire logic core_regulators_reduce,
    input wire logic last_level_cache_flushing,
    input wire logic last_level_cache_power_off,
    input wire logic io_supply,
    input wire logic regulator_low_power_state,
    input wire logic crystal_clk_stop,
    input wire logic typec_cold_state
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_state_codes: assert property (
        pkg_state inside {4'h0, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha,
        4'hb}) else $error("illegal package state code");
    a_c0_exit_c2: assert property (
        (pkg_state == 4'h0) ##1 (pkg_state != 4'h0) |-> pkg_state == 4'h2)
        else $error("left active state without passing c2");
    a_deep_no_c0: assert property (
        (pkg_state >= 4'h3) |=> pkg_state != 4'h0)
        else $error("deep state dropped straight to active");
    a_thread_c0: assert property (
        (thread_active != 8'h00) [*6] |-> pkg_state <= 4'h2)
        else $error("package deep while a thread runs");
    a_wake_cause: assert property (
        (core_wake != 4'h0) |-> ((core_wake & ~$past(core_break)) == 4'h0)
        && ($past(pkg_state) != 4'h0)) else $error("wake without break");
    a_self_refresh: assert property (
        mem_self_refresh == (pkg_state >= 4'h3))
        else $error("self refresh mismatch");
    a_base_clk: assert property (
        base_clk_stop == (pkg_state >= 4'h6)
        && core_regulators_reduce == base_clk_stop)
        else $error("base clock stop mismatch");
    a_flush_c7: assert property (
        last_level_cache_flushing |-> pkg_state == 4'h7)
        else $error("flushing outside c7");
    a_cache_off: assert property (
        last_level_cache_power_off |-> pkg_state >= 4'h7)
        else $error("cache off above c7");
    a_io_supply: assert property (
        io_supply == (pkg_state != 4'hb)) else $error("io supply mismatch");
    a_c10_clocks: assert property (
        crystal_clk_stop == (pkg_state == 4'hb)
        && regulator_low_power_state == crystal_clk_stop)
        else $error("c10 actions mismatch");
    a_typec_c10: assert property (
        typec_cold_state |-> pkg_state == 4'hb)
        else $error("type-c cold outside c10");
    c_deepest: cover property (pkg_state == 4'hb);
    c_wake: cover property (core_wake != 4'h0);
    c_cache_off: cover property ($rose(last_level_cache_power_off));
endmodule

bind pisr_top pisr_monitor pisr_monitor_inst (
    .pclk(pclk), .presetn(presetn), .thread_active(thread_active),
    .core_break(core_break), .pkg_state(pkg_state), .core_wake(core_wake),
    .mem_self_refresh(mem_self_refresh), .base_clk_stop(base_clk_stop),
    .core_regulators_reduce(core_regulators_reduce),
    .last_level_cache_flushing(last_level_cache_flushing),
    .last_level_cache_power_off(last_level_cache_power_off),
    .io_supply(io_supply),
    .regulator_low_power_state(regulator_low_power_state),
    .crystal_clk_stop(crystal_clk_stop), .typec_cold_state(typec_cold_state)
);

// ---- verif/pisr_platform_model.sv ----
`timescale 1ns/1ps
module pisr_platform_model (
    input wire logic pclk,
    input wire logic [3:0] grant,
    input wire logic keep_high,
    input wire logic access_go,
    output logic [3:0] latency_tolerance_report,
    output logic platform_hold,
    output logic mem_break,
    output logic mem_pending
);
    logic [3:0] lat_q = 4'hb;
    logic hold_q = 1'b0;
    logic brk_q = 1'b0;
    int left = 0;
    // one access at a time, pending for 30 cycles
    always @(posedge pclk) begin
        lat_q <= grant;
        hold_q <= keep_high;
        brk_q <= access_go && left == 0;
        if (access_go && left == 0) begin
            left <= 30;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign latency_tolerance_report = lat_q;
    assign platform_hold = hold_q;
    assign mem_break = brk_q;
    assign mem_pending = left > 0;
endmodule

// ---- verif/test_package_idle_state_resolver.sv ----
`timescale 1ns/1ps
module test_package_idle_state_resolver;
    import pisr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, mem_break, mem_pending, platform_hold;
    logic [NCORES*4-1:0] core_req = 16'hbbbb;
    logic [NCORES*NTHREADS-1:0] thread_active = 8'h00;
    logic [3:0] core_break = 4'h0, pkg_state, core_wake, grant = 4'hb, lat_tol;
    logic break_masked = 0, timer_event_near = 0, graphics_deep_idle = 1;
    logic display_off = 1, panel_self_refresh = 0, single_panel = 0;
    logic sr_cap = 0, typec_attached = 0, keep_high = 0, access_go = 0;
    logic self_ref, bclk, creg, flushing, cache_off, io_sup, reg_lp, xtal, tcold;
    int bad_count = 0, n_tests = 0, cyc = 0;

    always #2.5 pclk = ~pclk;

    pisr_top pisr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_req(core_req), .thread_active(thread_active),
        .core_break(core_break), .break_masked(break_masked),
        .latency_tolerance_report(lat_tol),
        .timer_event_near(timer_event_near),
        .graphics_deep_idle(graphics_deep_idle), .display_off(display_off),
        .panel_self_refresh(panel_self_refresh),
        .single_embedded_panel(single_panel),
        .panel_self_refresh_capable(sr_cap),
        .typec_attached(typec_attached), .mem_break(mem_break),
        .mem_pending(mem_pending), .platform_hold(platform_hold),
        .pkg_state(pkg_state), .core_wake(core_wake),
        .mem_self_refresh(self_ref), .base_clk_stop(bclk),
        .core_regulators_reduce(creg), .last_level_cache_flushing(flushing),
        .last_level_cache_power_off(cache_off), .io_supply(io_sup),
        .regulator_low_power_state(reg_lp), .crystal_clk_stop(xtal),
        .typec_cold_state(tcold));

    pisr_platform_model pisr_platform_model_inst (.pclk(pclk), .grant(grant),
        .keep_high(keep_high), .access_go(access_go),
        .latency_tolerance_report(lat_tol), .platform_hold(platform_hold),
        .mem_break(mem_break), .mem_pending(mem_pending));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_pkg(input logic [3:0] exp, input int max);
        int k;
        k = 0;
        while (pkg_state !== exp && k < max) begin
            @(posedge pclk);
            k++;
        end
        chk(pkg_state, exp);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic set_cores(input logic [15:0] v, input logic [3:0] e);
        @(posedge pclk);
        core_req <= v;
        wait_pkg(e, 20);
    endtask

    task automatic t_deep();
        wait_pkg(4'hb, 30);
        chk(xtal & reg_lp, 1);
        chk(io_sup, 0);
        chk(tcold, 1);
        typec_attached <= 1;
        repeat (6) @(posedge pclk);
        chk(tcold, 0);
        typec_attached <= 0;
        $display("done deep");
    endtask

    task automatic t_regs();
        apb(0, 8'h00, 0);
        chk(rd, 32'h000000b5);
        apb(1, 8'h04, 32'hffffffff);
        apb(0, 8'h04, 0);
        chk(rd[3:0], 4'hb);
        apb(0, 8'h08, 0);
        chk({err, rd}, {1'b1, 32'h0});
        $display("done regs");
    endtask

    task automatic t_grants();
        logic [3:0] g [8] = '{4'h6, 4'h3, 4'h4, 4'h2, 4'h7, 4'h8, 4'h9, 4'ha};
        logic [3:0] e;
        for (int i = 0; i < 8; i++) begin
            e = (g[i] == 4'h4) ? 4'h3 : g[i];
            @(posedge pclk);
            grant <= g[i];
            wait_pkg(e, 20);
            chk(self_ref, e >= 4'h3);
            chk(bclk & creg, e >= 4'h6);
        end
        grant <= 4'hb;
        timer_event_near <= 1;
        wait_pkg(4'h2, 20);
        timer_event_near <= 0;
        wait_pkg(4'hb, 20);
        $display("done grants");
    endtask

    task automatic t_display();
        display_off <= 0;
        panel_self_refresh <= 1;
        single_panel <= 1;
        sr_cap <= 1;
        repeat (6) @(posedge pclk);
        chk(pkg_state, 4'hb);
        single_panel <= 0;
        wait_pkg(4'h9, 20);
        display_off <= 1;
        wait_pkg(4'hb, 20);
        $display("done display");
    endtask

    task automatic t_cores();
        set_cores(16'hbbb6, 4'h6);
        set_cores(16'hbbbb, 4'hb);
        thread_active <= 8'h04;
        wait_pkg(4'h0, 20);
        thread_active <= 8'h00;
        wait_pkg(4'hb, 20);
        graphics_deep_idle <= 0;
        wait_pkg(4'h0, 20);
        graphics_deep_idle <= 1;
        wait_pkg(4'hb, 20);
        $display("done cores");
    endtask

    task automatic t_flush();
        int k;
        k = 0;
        set_cores(16'h6666, 4'h6);
        set_cores(16'h7777, 4'h7);
        chk(flushing, 1);
        while (cache_off !== 1'b1 && k < 400) begin
            @(posedge pclk);
            k++;
        end
        chk(k >= 7 * FLUSH_WAY_CYC && k <= 8 * FLUSH_WAY_CYC + 5, 1);
        set_cores(16'h6666, 4'h6);
        chk(cache_off, 0);
        set_cores(16'h8888, 4'h8);
        repeat (3) @(posedge pclk);
        chk({cache_off, flushing}, 2'b10);
        set_cores(16'hbbbb, 4'hb);
        $display("done flush");
    endtask

    task automatic t_break(input logic m, input logic [3:0] c);
        @(posedge pclk);
        core_break <= c;
        break_masked <= m;
        @(posedge pclk);
        core_break <= 4'h0;
        break_masked <= 0;
        @(posedge pclk);
        chk(core_wake, c);
    endtask

    task automatic t_breaks();
        t_break(1, 4'h2);
        wait_pkg(4'h2, 10);
        wait_pkg(4'hb, 20);
        t_break(0, 4'h4);
        wait_pkg(4'h0, 10);
        repeat (20) @(posedge pclk);
        chk(pkg_state, 4'h0);
        set_cores(16'hb0bb, 4'h0);
        set_cores(16'hbbbb, 4'hb);
        $display("done breaks");
    endtask

    task automatic t_mem(input logic h);
        @(posedge pclk);
        keep_high <= h;
        access_go <= 1;
        @(posedge pclk);
        access_go <= 0;
        wait_pkg(4'h2, 10);
        repeat (h ? 60 : 10) @(posedge pclk);
        chk(pkg_state, 4'h2);
        keep_high <= 0;
        wait_pkg(4'hb, 40);
        $display("done mem");
    endtask

    task automatic t_heur();
        apb(1, 8'h00, 32'h00000067);
        wait_pkg(4'h6, 20);
        apb(1, 8'h00, 32'h00000066);
        wait_pkg(4'h0, 20);
        apb(1, 8'h00, 32'h000000b1);
        wait_pkg(4'hb, 20);
        chk(tcold, 0);
        apb(1, 8'h00, 32'h000000b5);
        wait_pkg(4'hb, 20);
        repeat (2) @(posedge pclk);
        chk(tcold, 1);
        $display("done heuristic");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_deep();
        t_regs();
        t_grants();
        t_display();
        t_cores();
        t_flush();
        t_breaks();
        t_mem(0);
        t_mem(1);
        t_heur();
        tally_and_finish();
    end
endmodule
